// *** fprl_channel.sv ***
`timescale 1ns/10ps
module fprl_channel import fprl_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic tick,
	input wire fprl_chan_cfg_s cfg,
	input wire logic [7:0] target,
	output logic [7:0] duty
);

	logic [1:0] quarter;
	logic step_ok;
	logic [7:0] step;
	logic [7:0] next_duty;

	// ------------------------------------------------------------
	// Update tick, slowed by four
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			quarter <= 2'h0;
		end else if (ce && tick) begin
			quarter <= quarter + 2'h1;
		end
	end

	assign step_ok = ce && tick && (!cfg.slow || quarter == SLOW_LAST);
	assign step = fprl_step_slots(cfg.code);

	// ------------------------------------------------------------
	// Step toward target
	// ------------------------------------------------------------
	always_comb begin
		next_duty = duty;
		if (!cfg.enable) begin
			next_duty = target;
		end else if (step_ok) begin
			if (target > duty) begin
				next_duty = (8'(target - duty) < step) ? target : 8'(duty + step);
			end else if (target < duty) begin
				next_duty = (8'(duty - target) < step) ? target : 8'(duty - step);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			duty <= DUTY_RESET;
		end else if (ce) begin
			duty <= next_duty;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	bypass_follow_a: assert property (@(posedge clk) disable iff (reset)
		(ce && !cfg.enable) |=> duty == $past(target)) else $error("Duty did not follow target in bypass");

	step_up_a: assert property (@(posedge clk) disable iff (reset)
		(step_ok && cfg.enable && target > duty && 8'(target - duty) >= step)
		|=> duty == 8'($past(duty) + $past(step))) else $error("Wrong upward step");

	step_down_a: assert property (@(posedge clk) disable iff (reset)
		(step_ok && cfg.enable && target < duty && 8'(duty - target) >= step)
		|=> duty == 8'($past(duty) - $past(step))) else $error("Wrong downward step");

	no_overshoot_a: assert property (@(posedge clk) disable iff (reset)
		(step_ok && cfg.enable && target != duty && ((target > duty) ? 8'(target - duty) : 8'(duty - target)) < step)
		|=> duty == $past(target)) else $error("Step passed target");

	hold_between_a: assert property (@(posedge clk) disable iff (reset)
		(cfg.enable && !step_ok) |=> $stable(duty)) else $error("Duty moved without a tick");

	slow_gate_a: assert property (@(posedge clk) disable iff (reset)
		(ce && tick && cfg.slow && cfg.enable && quarter != SLOW_LAST && target != duty)
		|=> $stable(duty)) else $error("Slow channel stepped early");

endmodule : fprl_channel

// *** fprl_fan_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Fan on a PWM output: speed follows duty, largest jump kept
// ------------------------------------------------------------
module fprl_fan_model (
	input wire logic clk,
	input wire logic clear,
	input wire logic [7:0] duty,
	output logic [7:0] speed,
	output logic [7:0] max_jump
);
	logic [7:0] jump;
	assign jump = (duty > speed) ? duty - speed : speed - duty;
	initial begin
		speed = 8'h00;
		max_jump = 8'h00;
	end
	always @(posedge clk) begin
		speed <= duty;
		if (clear) begin
			max_jump <= 8'h00;
		end else if (jump > max_jump) begin
			max_jump <= jump;
		end
	end
endmodule : fprl_fan_model

// *** fprl_pkg.sv ***
package fprl_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] PWM1_CONFIG_ADDR = 8'h5c;
	localparam logic [7:0] PWM2_CONFIG_ADDR = 8'h5d;
	localparam logic [7:0] PWM3_CONFIG_ADDR = 8'h5e;
	localparam logic [7:0] RAMP_CTRL_CH1_ADDR = 8'h62;
	localparam logic [7:0] RAMP_CTRL_CH2_CH3_ADDR = 8'h63;
	localparam logic [7:0] DUTY_CH1_ADDR = 8'h30;
	localparam logic [7:0] DUTY_CH2_ADDR = 8'h31;
	localparam logic [7:0] DUTY_CH3_ADDR = 8'h32;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SLOW_BIT = 3;
	localparam int EN_CH1_BIT = 3;
	localparam int EN_CH2_BIT = 7;
	localparam int EN_CH3_BIT = 3;
	localparam int CODE_CH1_LSB = 0;
	localparam int CODE_CH2_LSB = 4;
	localparam int CODE_CH3_LSB = 0;
	localparam int CODE_W = 3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] RAMP_CTRL_RESET = 8'h00;
	localparam logic [7:0] DUTY_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam longint unsigned CLK_HZ = 64'd125_000_000;
	localparam longint unsigned DUTY_SLOTS = 64'd255;
	localparam longint unsigned RAMP_FULL_S = 64'd35;
	localparam longint unsigned TICK_CYCLES_DEF = RAMP_FULL_S * CLK_HZ / DUTY_SLOTS;
	localparam logic [1:0] SLOW_LAST = 2'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic enable;
		logic slow;
		logic [CODE_W-1:0] code;
	} fprl_chan_cfg_s;

	// Step size in slots for a ramp code
	function automatic logic [7:0] fprl_step_slots(input logic [CODE_W-1:0] code);
		logic [7:0] s;
		s = 8'h01;
		case (code)
			3'h0: s = 8'h01;
			3'h1: s = 8'h02;
			3'h2: s = 8'h03;
			3'h3: s = 8'h05;
			3'h4: s = 8'h08;
			3'h5: s = 8'h0c;
			3'h6: s = 8'h18;
			default: s = 8'h30;
		endcase
		return s;
	endfunction : fprl_step_slots

endpackage : fprl_pkg

// *** fprl_top.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - Ramp control one bit 3 enables step limiting on channel one.
// - Ramp control two bit 7 enables step limiting on channel two.
// - Ramp control two bit 3 enables step limiting on channel three.
// - Duty counts high slots out of 255 per PWM period.
// - Codes 0 to 7 give steps of 1, 2, 3, 5, 8, 12, 24, 48 slots.
// - Enabled and target above duty: raise duty by the step, landing on the target when it is nearer than one step.
// - Enabled and target below duty: lower duty by the step, landing on the target when it is nearer than one step.
// - Each stepped result becomes the stored duty and drives the output.
// - Ramp control one bits 2 to 0 give channel one's code.
// - Ramp control two bits 2 to 0 give channel three's code.
// - Ramp control two bits 6 to 4 give channel two's code.
// - Normal full ramp takes about 35 s at step 1, scaling with step.
// - Config bit 3 of each channel slows its ramp by four.
// - Slowed full ramp takes about 140 s at step 1.
// - With ramping off, the target passes straight to the output.
module fprl_top import fprl_pkg::*; #(
	parameter int unsigned TICK_CYCLES = 32'(TICK_CYCLES_DEF),
	parameter int NUM_CH = 3
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [7:0] target_ch1,
	input wire logic [7:0] target_ch2,
	input wire logic [7:0] target_ch3,
	output logic [7:0] duty_ch1,
	output logic [7:0] duty_ch2,
	output logic [7:0] duty_ch3
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] pwm1_config;
	logic [7:0] pwm2_config;
	logic [7:0] pwm3_config;
	logic [7:0] ramp_ctrl_ch1;
	logic [7:0] ramp_ctrl_ch2_ch3;

	logic [31:0] tick_cnt;
	logic tick;
	fprl_chan_cfg_s cfg [NUM_CH];
	logic [7:0] target [NUM_CH];
	logic [7:0] duty [NUM_CH];

	// Register writes
	always_ff @(posedge clk) begin
		if (reset) begin
			pwm1_config <= CONFIG_RESET;
			pwm2_config <= CONFIG_RESET;
			pwm3_config <= CONFIG_RESET;
			ramp_ctrl_ch1 <= RAMP_CTRL_RESET;
			ramp_ctrl_ch2_ch3 <= RAMP_CTRL_RESET;
		end else if (ce && reg_write) begin
			if (reg_addr == PWM1_CONFIG_ADDR) begin
				pwm1_config <= reg_wdata;
			end else if (reg_addr == PWM2_CONFIG_ADDR) begin
				pwm2_config <= reg_wdata;
			end else if (reg_addr == PWM3_CONFIG_ADDR) begin
				pwm3_config <= reg_wdata;
			end else if (reg_addr == RAMP_CTRL_CH1_ADDR) begin
				ramp_ctrl_ch1 <= reg_wdata;
			end else if (reg_addr == RAMP_CTRL_CH2_CH3_ADDR) begin
				ramp_ctrl_ch2_ch3 <= reg_wdata;
			end
		end
	end

	// Register reads, one cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= UNMAPPED_READ;
			reg_rvalid <= 1'b0;
		end else if (ce) begin
			reg_rvalid <= reg_read;
			if (reg_read) begin
				if (reg_addr == PWM1_CONFIG_ADDR) begin
					reg_rdata <= pwm1_config;
				end else if (reg_addr == PWM2_CONFIG_ADDR) begin
					reg_rdata <= pwm2_config;
				end else if (reg_addr == PWM3_CONFIG_ADDR) begin
					reg_rdata <= pwm3_config;
				end else if (reg_addr == RAMP_CTRL_CH1_ADDR) begin
					reg_rdata <= ramp_ctrl_ch1;
				end else if (reg_addr == RAMP_CTRL_CH2_CH3_ADDR) begin
					reg_rdata <= ramp_ctrl_ch2_ch3;
				end else if (reg_addr == DUTY_CH1_ADDR) begin
					reg_rdata <= duty[0];
				end else if (reg_addr == DUTY_CH2_ADDR) begin
					reg_rdata <= duty[1];
				end else if (reg_addr == DUTY_CH3_ADDR) begin
					reg_rdata <= duty[2];
				end else begin
					reg_rdata <= UNMAPPED_READ;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Channel configuration decode
	// ------------------------------------------------------------
	always_comb begin
		cfg[0].enable = ramp_ctrl_ch1[EN_CH1_BIT];
		cfg[0].code = ramp_ctrl_ch1[CODE_CH1_LSB +: CODE_W];
		cfg[0].slow = pwm1_config[SLOW_BIT];
		cfg[1].enable = ramp_ctrl_ch2_ch3[EN_CH2_BIT];
		cfg[1].code = ramp_ctrl_ch2_ch3[CODE_CH2_LSB +: CODE_W];
		cfg[1].slow = pwm2_config[SLOW_BIT];
		cfg[2].enable = ramp_ctrl_ch2_ch3[EN_CH3_BIT];
		cfg[2].code = ramp_ctrl_ch2_ch3[CODE_CH3_LSB +: CODE_W];
		cfg[2].slow = pwm3_config[SLOW_BIT];
	end

	assign target[0] = target_ch1;
	assign target[1] = target_ch2;
	assign target[2] = target_ch3;

	// ------------------------------------------------------------
	// Duty update tick
	// ------------------------------------------------------------
	// One slot per tick over 255 slots gives the 35 s full ramp at step 1
	always_ff @(posedge clk) begin
		if (reset) begin
			tick_cnt <= 32'h0;
			tick <= 1'b0;
		end else if (ce) begin
			if (tick_cnt >= TICK_CYCLES - 1) begin
				tick_cnt <= 32'h0;
				tick <= 1'b1;
			end else begin
				tick_cnt <= tick_cnt + 32'h1;
				tick <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Ramp channels
	// ------------------------------------------------------------
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		fprl_channel u_ch (
			.clk(clk),
			.reset(reset),
			.ce(ce),
			.tick(tick),
			.cfg(cfg[i]),
			.target(target[i]),
			.duty(duty[i])
		);
	end

	// 8-bit duty holds 0 to 255 high slots per period
	assign duty_ch1 = duty[0];
	assign duty_ch2 = duty[1];
	assign duty_ch3 = duty[2];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [31:0] since_tick;
	logic seen_tick;

	always_ff @(posedge clk) begin
		if (reset) begin
			since_tick <= 32'h0;
			seen_tick <= 1'b0;
		end else if (ce) begin
			if (tick) begin
				since_tick <= 32'h1;
				seen_tick <= 1'b1;
			end else begin
				since_tick <= since_tick + 32'h1;
			end
		end
	end

	tick_spacing_a: assert property (@(posedge clk) disable iff (reset)
		(tick && seen_tick) |-> since_tick == TICK_CYCLES) else $error("Tick spacing wrong");

	ch1_enable_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_write && reg_addr == RAMP_CTRL_CH1_ADDR)
		|=> cfg[0].enable == $past(reg_wdata[EN_CH1_BIT])) else $error("Channel one enable not taken");

	ch2_enable_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_write && reg_addr == RAMP_CTRL_CH2_CH3_ADDR)
		|=> cfg[1].enable == $past(reg_wdata[EN_CH2_BIT])) else $error("Channel two enable not taken");

	ch3_enable_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_write && reg_addr == RAMP_CTRL_CH2_CH3_ADDR)
		|=> cfg[2].enable == $past(reg_wdata[EN_CH3_BIT])) else $error("Channel three enable not taken");

	ch1_code_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_write && reg_addr == RAMP_CTRL_CH1_ADDR)
		|=> cfg[0].code == $past(reg_wdata[2:0])) else $error("Channel one code not taken");

	ch2_code_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_write && reg_addr == RAMP_CTRL_CH2_CH3_ADDR)
		|=> cfg[1].code == $past(reg_wdata[6:4])) else $error("Channel two code not taken");

	ch3_code_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_write && reg_addr == RAMP_CTRL_CH2_CH3_ADDR)
		|=> cfg[2].code == $past(reg_wdata[2:0])) else $error("Channel three code not taken");

	slow_bit_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_write && reg_addr == PWM2_CONFIG_ADDR)
		|=> cfg[1].slow == $past(reg_wdata[SLOW_BIT])) else $error("Slow bit not taken");

	duty_readback_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_read && reg_addr == DUTY_CH1_ADDR)
		|=> reg_rvalid && reg_rdata == $past(duty[0])) else $error("Duty readback wrong");

	// ------------------------------------------------------------
	// Slow bits, readback, bypass, tick and freeze checks
	// ------------------------------------------------------------
	ch1_slow_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_write && reg_addr == PWM1_CONFIG_ADDR)
		|=> cfg[0].slow == $past(reg_wdata[SLOW_BIT])) else $error("Channel one slow bit not taken");

	ch3_slow_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_write && reg_addr == PWM3_CONFIG_ADDR)
		|=> cfg[2].slow == $past(reg_wdata[SLOW_BIT])) else $error("Channel three slow bit not taken");

	duty2_readback_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_read && reg_addr == DUTY_CH2_ADDR)
		|=> reg_rvalid && reg_rdata == $past(duty[1])) else $error("Channel two duty readback wrong");

	duty3_readback_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_read && reg_addr == DUTY_CH3_ADDR)
		|=> reg_rvalid && reg_rdata == $past(duty[2])) else $error("Channel three duty readback wrong");

	ctrl1_readback_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_read && reg_addr == RAMP_CTRL_CH1_ADDR)
		|=> reg_rdata[3] == $past(cfg[0].enable) && reg_rdata[2:0] == $past(cfg[0].code))
		else $error("Channel one control readback wrong");

	ctrl23_readback_a: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_read && reg_addr == RAMP_CTRL_CH2_CH3_ADDR)
		|=> reg_rdata[7] == $past(cfg[1].enable) && reg_rdata[6:4] == $past(cfg[1].code)
		&& reg_rdata[3] == $past(cfg[2].enable) && reg_rdata[2:0] == $past(cfg[2].code))
		else $error("Channel two and three control readback wrong");

	ch2_bypass_a: assert property (@(posedge clk) disable iff (reset)
		(ce && !cfg[1].enable) |=> duty_ch2 == $past(target_ch2)) else $error("Channel two bypass wrong");

	tick_pulse_a: assert property (@(posedge clk) disable iff (reset)
		(ce && tick && TICK_CYCLES > 1) |=> !tick) else $error("Tick longer than one cycle");

	tick_bound_a: assert property (@(posedge clk) disable iff (reset)
		tick_cnt < TICK_CYCLES) else $error("Tick counter out of range");

	freeze_duty_a: assert property (@(posedge clk) disable iff (reset)
		(!ce) |=> $stable(duty_ch1) && $stable(duty_ch2) && $stable(duty_ch3))
		else $error("Duty moved while frozen");

	freeze_regs_a: assert property (@(posedge clk) disable iff (reset)
		(!ce) |=> $stable(ramp_ctrl_ch1) && $stable(ramp_ctrl_ch2_ch3)
		&& $stable(pwm1_config) && $stable(pwm2_config) && $stable(pwm3_config))
		else $error("Register changed while frozen");

	freeze_tick_a: assert property (@(posedge clk) disable iff (reset)
		(!ce) |=> $stable(tick) && $stable(tick_cnt)) else $error("Tick moved while frozen");

endmodule : fprl_top

// *** fprl_top_test.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module fprl_top_test import fprl_pkg::*;;
	localparam int TICK = 10;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_write = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic [7:0] tgt [3] = '{8'h00, 8'h00, 8'h00};
	logic [7:0] duty [3];
	logic fan_clear = 1'b0;
	logic [7:0] fan_max;
	logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h18, 8'h30};
	int fail_count = 0;
	int checks_done = 0;
	always #4 clk = ~clk;
	fprl_top #(.TICK_CYCLES(TICK), .NUM_CH(3)) dut (.clk(clk), .reset(reset), .ce(ce),
		.reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .target_ch1(tgt[0]), .target_ch2(tgt[1]),
		.target_ch3(tgt[2]), .duty_ch1(duty[0]), .duty_ch2(duty[1]), .duty_ch3(duty[2]));
	fprl_fan_model fan (.clk(clk), .clear(fan_clear), .duty(duty[0]), .speed(), .max_jump(fan_max));
	// ------------------------------------------------------------
	// Bus and wait helpers
	// ------------------------------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 reg_write = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1 reg_write = 1'b0;
	endtask : reg_wr
	task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		#1 reg_read = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1 reg_read = 1'b0;
		`CHK(reg_rvalid, 1'b1)
		`CHK(reg_rdata, e)
	endtask : reg_chk
	task automatic wait_duty(input int ch, output int n);
		logic [7:0] prev;
		prev = duty[ch];
		for (n = 1; n < 200; n++) begin
			@(posedge clk);
			#1;
			if (duty[ch] !== prev) return;
		end
		fail_count++;
		complete_run();
	endtask : wait_duty
	task automatic zero_ch1(input logic [7:0] cfg);
		tgt[0] = 8'h00;
		reg_wr(RAMP_CTRL_CH1_ADDR, 8'h00);
		repeat (2) @(posedge clk);
		reg_wr(RAMP_CTRL_CH1_ADDR, cfg);
	endtask : zero_ch1
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		reg_chk(PWM1_CONFIG_ADDR, 8'h00);
		reg_chk(RAMP_CTRL_CH1_ADDR, 8'h00);
		reg_chk(RAMP_CTRL_CH2_CH3_ADDR, 8'h00);
		reg_wr(PWM2_CONFIG_ADDR, 8'ha5);
		reg_chk(PWM2_CONFIG_ADDR, 8'ha5);
		reg_wr(PWM2_CONFIG_ADDR, 8'h00);
		reg_wr(8'h70, 8'h5a);
		reg_chk(8'h70, 8'h00);
		reg_wr(PWM3_CONFIG_ADDR, 8'h08);
		reg_chk(PWM3_CONFIG_ADDR, 8'h08);
		reg_wr(PWM3_CONFIG_ADDR, 8'h00);
		reg_wr(DUTY_CH1_ADDR, 8'h55);
		reg_chk(DUTY_CH1_ADDR, 8'h00);
	endtask : t_regs
	task automatic t_bypass;
		@(posedge clk);
		#1 tgt[1] = 8'h77;
		@(posedge clk);
		#1 `CHK(duty[1], 8'h77)
		tgt[1] = 8'h00;
	endtask : t_bypass
	task automatic t_codes;
		int n;
		for (int c = 0; c < 8; c++) begin
			zero_ch1(8'h08 | 8'(c));
			fan_clear = 1'b0;
			tgt[0] = 8'hff;
			wait_duty(0, n);
			`CHK(duty[0], steps[c])
			wait_duty(0, n);
			`CHK(n, TICK)
			`CHK(duty[0], 8'(2 * steps[c]))
			`CHK(fan_max <= steps[c], 1'b1)
			fan_clear = 1'b1;
		end
		fan_clear = 1'b0;
	endtask : t_codes
	task automatic t_slow;
		int n;
		reg_wr(PWM1_CONFIG_ADDR, 8'h08);
		zero_ch1(8'h08);
		tgt[0] = 8'hff;
		wait_duty(0, n);
		wait_duty(0, n);
		`CHK(n, 4 * TICK)
		reg_wr(PWM1_CONFIG_ADDR, 8'h00);
	endtask : t_slow
	task automatic t_land;
		int n;
		logic [7:0] exp [6] = '{8'h08, 8'h10, 8'h14, 8'h0c, 8'h04, 8'h03};
		zero_ch1(8'h0c);
		tgt[0] = 8'h14;
		for (int i = 0; i < 6; i++) begin
			wait_duty(0, n);
			`CHK(duty[0], exp[i])
			if (i == 2) begin
				repeat (3 * TICK) @(posedge clk);
				#1 `CHK(duty[0], 8'h14)
				tgt[0] = 8'h03;
			end
		end
		reg_chk(DUTY_CH1_ADDR, 8'h03);
	endtask : t_land
	task automatic t_ch23;
		int n;
		reg_wr(RAMP_CTRL_CH2_CH3_ADDR, 8'he9);
		tgt[1] = 8'hff;
		tgt[2] = 8'hff;
		wait_duty(1, n);
		`CHK(duty[1], 8'h18)
		`CHK(duty[2], 8'h02)
		reg_chk(DUTY_CH2_ADDR, 8'h18);
		reg_chk(DUTY_CH3_ADDR, 8'h02);
		reg_wr(PWM3_CONFIG_ADDR, 8'h08);
		wait_duty(2, n);
		wait_duty(2, n);
		`CHK(n, 4 * TICK)
		`CHK(duty[2], 8'h06)
	endtask : t_ch23
	task automatic t_freeze;
		int n;
		logic [7:0] held;
		@(posedge clk);
		#1 ce = 1'b0;
		held = duty[2];
		tgt[0] = 8'h40;
		reg_write = 1'b1;
		reg_addr = RAMP_CTRL_CH1_ADDR;
		reg_wdata = 8'h00;
		repeat (5 * TICK) @(posedge clk);
		#1 `CHK(duty[0], 8'h03)
		`CHK(duty[2], held)
		reg_write = 1'b0;
		ce = 1'b1;
		wait_duty(0, n);
		`CHK(duty[0], 8'h0b)
	endtask : t_freeze
	task automatic t_reset;
		@(posedge clk);
		#1 reset = 1'b1;
		@(posedge clk);
		#1 `CHK(duty[0], 8'h00)
		reset = 1'b0;
		@(posedge clk);
		#1 `CHK(duty[0], 8'h40)
		reg_chk(RAMP_CTRL_CH1_ADDR, 8'h00);
		reg_chk(PWM3_CONFIG_ADDR, 8'h00);
	endtask : t_reset
	initial begin
		repeat (8) @(posedge clk);
		#1 reset = 1'b0;
		t_regs();
		t_bypass();
		t_codes();
		t_slow();
		t_land();
		t_ch23();
		t_freeze();
		t_reset();
		complete_run();
	end
endmodule : fprl_top_test
